// *** bench/ready_partner.sv ***
// external memory model that answers each bus cycle through the ready pin
`default_nettype none
module ready_partner (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic rd_strobe_n,
	input wire logic wr_strobe_n,
	input wire logic active_high, // ready polarity chosen for the cycle
	input wire logic [1:0] mode, // 0 never ready, 1 always ready, 2 ready after delay
	input wire logic [7:0] delay, // strobe-low ticks before ready is raised
	output logic ready_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------
	// ready generation
	// ------
	logic [7:0] low_cnt = 8'h00; // ticks the strobe has been low
	// starts deasserted so the pin carries a defined level before the first edge
	logic act = 1'b0; // ready asserted
	// changes only just after an edge, so the level is stable around the sample edge
	always @(posedge sys_clk) begin
		if (!rst_n || (rd_strobe_n && wr_strobe_n)) begin
			low_cnt <= 8'h00;
			// in mode 2 withdrawn one tick after the strobe ends, inside the release window; mode 1 keeps it asserted
			act <= (mode == 2'h1);
		end else begin
			low_cnt <= low_cnt + 8'h01;
			// once raised it stays until the strobe ends, well beyond the async minimum
			act <= (mode == 2'h1) || (mode == 2'h2 && low_cnt >= delay);
		end
	end
	// inactive level is the inverse of the active one, never left floating
	assign ready_pin = act ? active_high : !active_high;
endmodule // ready_partner
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench of the external bus wait-state controller
`default_nettype none
module testbench
	import ready_wait_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ------
	// signals
	// ------
	logic sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic ready_pin, bus_clock_output, addr_latch, rd_strobe_n, wr_strobe_n, bus_busy;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, d; // d: last read word
	logic [1:0] s_axi_bresp, s_axi_rresp, r, p_mode; // r: last response
	logic [7:0] p_delay; // partner ready delay
	logic p_high; // partner ready polarity
	logic al_prev = 1'b0, rst_prev = 1'b0, clk_prev = 1'b0, was_wr = 1'b0;
	int n_errors, total_checks, n_cycles, n_starts, al_cnt, lo_cnt, pre_cnt, post_cnt, last_post;
	int clk_bad, lo, lo2, base;
	ext_bus_ready_wait_control i_dut (
		.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.ready_pin, .bus_clock_output, .addr_latch, .rd_strobe_n, .wr_strobe_n, .bus_busy
	);
	ready_partner i_partner (.sys_clk, .rst_n, .rd_strobe_n, .wr_strobe_n, .active_high(p_high),
		.mode(p_mode), .delay(p_delay), .ready_pin);
	// 250 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// ------
	// cycle monitor: ticks of latch, strobe delay, strobe low and post waits
	// ------
	always @(posedge sys_clk) begin
		if (addr_latch && !al_prev) begin
			last_post = post_cnt;
			n_starts++;
			al_cnt = 0;
			lo_cnt = 0;
			pre_cnt = 0;
			post_cnt = 0;
		end
		if (addr_latch) al_cnt++;
		else if (!(rd_strobe_n && wr_strobe_n)) begin
			lo_cnt++;
			was_wr = !wr_strobe_n;
		end else if (bus_busy && lo_cnt == 0) pre_cnt++;
		else if (bus_busy) post_cnt++;
		// bus clock must flip on every tick once out of reset
		if (rst_prev && rst_n && bus_clock_output === clk_prev) clk_bad++;
		al_prev = addr_latch;
		rst_prev = rst_n;
		clk_prev = bus_clock_output;
	end
	// ------
	// tasks
	// ------
	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task results();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// address and data offered together, each dropped once taken
	task axi_write(input logic [3:0] a, input logic [31:0] dat);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= dat;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge sys_clk);
			if (s_axi_awready) aw_ok = 1'b1;
			if (s_axi_wready) w_ok = 1'b1;
			if (aw_ok) s_axi_awvalid <= 1'b0;
			if (w_ok) s_axi_wvalid <= 1'b0;
		end
		do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task axi_read(input logic [3:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// program, queue one command, wait for the end and check the cycle shape
	task cyc(input logic [9:0] ctrl, input logic wr, input logic [1:0] pm, input logic [7:0] pd, input int exp_lo);
		int n;
		n = 0;
		p_mode <= pm;
		p_delay <= pd;
		p_high <= ctrl[READY_HIGH_BIT];
		axi_write(CTRL_OFFSET, 32'(ctrl));
		base = n_starts;
		axi_write(CMD_OFFSET, 32'(wr));
		for (; n < 20 && bus_busy !== 1'b1; n++) @(posedge sys_clk);
		for (; n < 400 && bus_busy !== 1'b0; n++) @(posedge sys_clk);
		n_cycles++;
		check("cycle started", base + 1, n_starts);
		check("cycle finished", 1, n < 400);
		check("latch ticks", 2, al_cnt);
		check("strobe delay ticks", ctrl[RW_DELAY_BIT], pre_cnt);
		check("strobe direction", wr, was_wr);
		check("post wait ticks", 2 * (ctrl[MUX_BIT] + ctrl[TURNAROUND_BIT]), post_cnt);
		if (exp_lo >= 0) check("strobe low ticks", exp_lo, lo_cnt);
		lo = lo_cnt;
	endtask
	// ------
	// test sequence
	// ------
	initial begin
		rst_n = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, p_high} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, p_mode, p_delay} = '0;
		s_axi_wstrb = 4'hF;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		check("strobe idle", 1, rd_strobe_n & wr_strobe_n);
		// register map: reset value, readback, unmapped place
		axi_read(CTRL_OFFSET);
		check("ctrl reset", 32'(CTRL_RESET), d);
		axi_read(4'hC);
		check("unmapped read resp", RESP_SLVERR, r);
		check("unmapped read data", 0, d);
		axi_write(4'hC, 32'h0000_0001);
		check("unmapped write resp", RESP_SLVERR, r);
		axi_write(CTRL_OFFSET, 32'h0000_03FF);
		axi_read(CTRL_OFFSET);
		check("ctrl readback", 32'h0000_03FF, d);
		// programmed length only, ready ignored while disabled
		for (int m = 0; m < 16; m += 5) cyc(10'(m), m[0], 2'h0, 8'h00, 2 * (m + 1));
		cyc(10'h011, 1'b1, 2'h0, 8'h00, 3);
		// ready already active: no wait, every polarity and sync mode
		for (int k = 0; k < 4; k++) cyc(10'h082 | 10'(k << 8), k[0], 2'h1, 8'h00, 6);
		// late ready: two more ticks of delay cost exactly one more wait
		for (int k = 0; k < 4; k++) begin
			cyc(10'h080 | 10'(k << 8), k[0], 2'h2, 8'h06, -1);
			lo2 = lo;
			cyc(10'h080 | 10'(k << 8), k[0], 2'h2, 8'h08, -1);
			check("wait inserted", 1, lo2 > 2);
			check("one wait per sample", lo2 + 2, lo);
			axi_read(STATUS_OFFSET);
			check("ready waits", (lo - 2) / 2, d[15:8]);
		end
		// post-cycle waits for every mux and turnaround setting
		for (int k = 0; k < 4; k++) cyc(10'(k << 5), k[0], 2'h0, 8'h00, 2);
		// back to back: second command waits for all post waits
		axi_write(CTRL_OFFSET, 32'h0000_0060);
		base = n_starts;
		axi_write(CMD_OFFSET, 32'h0000_0001);
		for (int i = 0; i < 50 && n_starts == base; i++) @(posedge sys_clk);
		axi_write(CMD_OFFSET, 32'h0000_0000);
		for (int i = 0; i < 400 && n_starts < base + 2; i++) @(posedge sys_clk);
		for (int i = 0; i < 400 && bus_busy !== 1'b0; i++) @(posedge sys_clk);
		n_cycles += 2;
		check("gap before next cycle", 1, last_post >= 4);
		check("second cycle read", 0, was_wr);
		axi_read(CMD_OFFSET);
		check("last direction", 0, d[0]);
		axi_read(STATUS_OFFSET);
		check("cycle count", n_cycles, d[31:16]);
		check("bus clock toggles", 0, clk_bad);
		// sticky short-pulse flag: clear while aligned ready cannot set it
		axi_write(STATUS_OFFSET, 32'h0000_0004);
		check("status write resp", RESP_OKAY, r);
		axi_read(STATUS_OFFSET);
		check("short flag cleared", 0, d[2]);
		check("idle, none pending", 0, d[1:0]);
		// unaligned active-low ready, then a two-tick pulse made by flipping the partner polarity
		axi_write(CTRL_OFFSET, 32'h0000_0200);
		p_high <= 1'b1;
		repeat (2) @(posedge sys_clk);
		p_high <= 1'b0;
		repeat (6) @(posedge sys_clk);
		axi_read(STATUS_OFFSET);
		check("short flag set", 1, d[2]);
		results();
	end
	// watchdog: the sequence needs a few hundred ticks, far below the 25000 allowed
	initial begin
		#100000;
		n_errors++;
		results();
	end
endmodule // testbench
`default_nettype wire

// *** src/ext_bus_ready_wait_control.sv ***
// external bus cycle engine with programmed, ready and post-cycle wait states
// Function
// [R01] run programmed length and waits before sampling ready
// [R02] delay strobe leading edge when rw delay set
// [R03] inactive ready adds one wait, resample
// [R04] active ready ends the running cycle
// [R05] partner may drop ready at strobe end
// [R06] synchronous ready sampled at bus clock edge
// [R07] asynchronous ready synchronised internally, minimum width
// [R08] multiplexed bus gives longer ready release window
// [R09] multiplexed mode appends one wait after cycle
// [R10] turnaround option appends one more wait
// [R11] gap two cycles mux+turnaround, zero demux
// [R12] next cycle starts only after all waits
`default_nettype none
module ext_bus_ready_wait_control
	import ready_wait_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ready_pin,
	output logic bus_clock_output,
	output logic addr_latch,
	output logic rd_strobe_n,
	output logic wr_strobe_n,
	output logic bus_busy
);
	// ----------------------------------------------------------------------
	// register bus slave
	// ----------------------------------------------------------------------
	logic aw_held, w_held; // address / data captured, waiting for partner
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [CTRL_W-1:0] ctrl; // software configuration
	logic pending, pend_write; // one queued command and its direction
	logic short_ready; // sticky: async ready pulse too short
	logic [7:0] last_waits; // ready waits of the last cycle
	logic [15:0] cycle_count; // completed cycles
	logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
	logic [3:0] next_aw_addr, next_w_strb;
	logic [31:0] next_w_data, next_rdata;
	logic [1:0] next_bresp, next_rresp;
	logic [CTRL_W-1:0] next_ctrl;
	logic next_pending, next_pend_write, next_short;
	logic do_write; // both halves present, response slot free
	logic cmd_write; // write hit on the command register
	logic start; // a cycle begins this tick
	logic short_seen; // from the ready monitor below
	// decode of a byte address, used for reads and writes alike
	function automatic logic [1:0] reg_sel(input logic [3:0] a);
		unique case (a)
			CTRL_OFFSET: reg_sel = 2'h1;
			CMD_OFFSET: reg_sel = 2'h2;
			STATUS_OFFSET: reg_sel = 2'h3;
			default: reg_sel = 2'h0;
		endcase
	endfunction
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign cmd_write = do_write && reg_sel(aw_addr) == 2'h2 && w_strb[0];
	// next values of the slave and of software-visible state
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		next_ctrl = ctrl;
		next_pending = pending;
		next_pend_write = pend_write;
		next_short = short_ready;
		if (s_axi_awvalid && !aw_held) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (start) begin
			next_pending = 1'b0; // taken by the engine
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (reg_sel(aw_addr) == 2'h0) ? RESP_SLVERR : RESP_OKAY;
			if (reg_sel(aw_addr) == 2'h1) begin
				if (w_strb[0]) next_ctrl[7:0] = w_data[7:0];
				if (w_strb[1]) next_ctrl[CTRL_W-1:8] = w_data[CTRL_W-1:8];
			end
			// a command while one waits is dropped: only one can queue
			if (cmd_write && (!pending || start)) begin
				next_pending = 1'b1;
				next_pend_write = w_data[CMD_WRITE_BIT];
			end
			if (reg_sel(aw_addr) == 2'h3 && w_strb[0] && w_data[ST_SHORT_BIT]) begin
				next_short = 1'b0;
			end
		end
		if (short_seen) begin
			next_short = 1'b1; // a new event beats a clear in the same cycle
		end
		if (s_axi_arvalid && !s_axi_rvalid) begin
			next_rvalid = 1'b1;
			next_rresp = RESP_OKAY;
			unique case (reg_sel(s_axi_araddr))
				2'h1: next_rdata = {{(32 - CTRL_W){1'b0}}, ctrl};
				2'h2: next_rdata = {31'h0, pend_write};
				2'h3: next_rdata = {cycle_count, last_waits, 5'h00, short_ready, pending, bus_busy};
				default: begin
					next_rdata = 32'h0;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
			ctrl <= CTRL_RESET;
			pending <= 1'b0;
			pend_write <= 1'b0;
			short_ready <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			ctrl <= next_ctrl;
			pending <= next_pending;
			pend_write <= next_pend_write;
			short_ready <= next_short;
		end
	end
	// ----------------------------------------------------------------------
	// ready input path
	// ----------------------------------------------------------------------
	logic ready_sync2, ready_sync3;
	logic ready_level; // level after the selected synchroniser
	logic ready_active; // polarity applied
	logic [3:0] active_run; // length of the current async active pulse
	logic [3:0] next_active_run;
	ready_sync u_ready_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ready_pin(ready_pin),
		.ready_sync2(ready_sync2),
		.ready_sync3(ready_sync3)
	);
	// aligned ready uses the short chain; unaligned ready takes one more stage
	assign ready_level = ctrl[READY_ASYNC_BIT] ? ready_sync3 : ready_sync2; // R06 R07
	assign ready_active = ctrl[READY_HIGH_BIT] ? ready_level : !ready_level;
	assign short_seen = ctrl[READY_ASYNC_BIT] && !ready_active && active_run != 4'h0
		&& active_run < 4'(ASYNC_READY_MIN_CYC); // R07
	// pulse width monitor for unaligned ready
	always_comb begin
		next_active_run = 4'h0;
		if (ready_active) begin
			next_active_run = (active_run == 4'hF) ? active_run : active_run + 4'h1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			active_run <= 4'h0;
		end else begin
			active_run <= next_active_run;
		end
	end
	// ----------------------------------------------------------------------
	// bus cycle engine
	// ----------------------------------------------------------------------
	bus_state_e state, next_state;
	logic phase, next_phase; // bus clock level; high half ends a bus clock cycle
	logic first_half, next_first_half; // first tick of the command phase
	logic [MCW_W-1:0] wait_left, next_wait_left; // programmed waits still to run
	logic cur_write, next_cur_write;
	logic [7:0] waits, next_waits;
	logic [7:0] next_last_waits;
	logic [15:0] next_cycle_count;
	logic bus_edge; // last tick of a bus clock cycle
	logic sample_pt; // ready sampling point
	logic strobe_on;
	assign bus_edge = phase;
	assign sample_pt = state == S_CMD && bus_edge && wait_left == '0; // R01
	assign start = state == S_IDLE && pending && bus_edge; // R12
	// the delayed strobe skips the first tick of the command phase
	assign strobe_on = state == S_CMD && !(first_half && ctrl[RW_DELAY_BIT]); // R02
	assign rd_strobe_n = !(strobe_on && !cur_write);
	assign wr_strobe_n = !(strobe_on && cur_write);
	assign bus_clock_output = phase;
	assign addr_latch = state == S_ADDR;
	assign bus_busy = state != S_IDLE;
	// state, counters and status of one external cycle
	always_comb begin
		next_state = state;
		next_phase = !phase;
		next_first_half = 1'b0;
		next_wait_left = wait_left;
		next_cur_write = cur_write;
		next_waits = waits;
		next_last_waits = last_waits;
		next_cycle_count = cycle_count;
		unique case (state)
			S_IDLE: begin
				if (start) begin
					next_state = S_ADDR;
					next_cur_write = pend_write;
				end
			end
			S_ADDR: begin
				if (bus_edge) begin
					next_state = S_CMD;
					next_first_half = 1'b1;
					next_wait_left = ctrl[MCW_LSB +: MCW_W]; // R01
					next_waits = 8'h00;
				end
			end
			S_CMD: begin
				if (bus_edge && wait_left != '0) begin
					next_wait_left = wait_left - 1'b1; // R01
				end else if (sample_pt && ctrl[READY_EN_BIT] && !ready_active) begin
					// partner not ready: one more bus cycle, sample again
					next_waits = (waits == 8'hFF) ? waits : waits + 8'h01; // R03
				end else if (sample_pt) begin
					next_last_waits = waits; // R04
					next_cycle_count = cycle_count + 16'h0001;
					if (ctrl[MUX_BIT]) begin
						next_state = S_MUX; // R09 R08
					end else if (ctrl[TURNAROUND_BIT]) begin
						next_state = S_TRI; // R10
					end else begin
						next_state = S_IDLE; // R11
					end
				end
			end
			S_MUX: begin
				if (bus_edge) begin
					next_state = ctrl[TURNAROUND_BIT] ? S_TRI : S_IDLE; // R10 R11
				end
			end
			S_TRI: begin
				if (bus_edge) begin
					next_state = S_IDLE; // R12
				end
			end
			default: next_state = S_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= S_IDLE;
			phase <= 1'b0;
			first_half <= 1'b0;
			wait_left <= '0;
			cur_write <= 1'b0;
			waits <= 8'h00;
			last_waits <= 8'h00;
			cycle_count <= 16'h0000;
		end else begin
			state <= next_state;
			phase <= next_phase;
			first_half <= next_first_half;
			wait_left <= next_wait_left;
			cur_write <= next_cur_write;
			waits <= next_waits;
			last_waits <= next_last_waits;
			cycle_count <= next_cycle_count;
		end
	end
	// ----------------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------------
	logic [7:0] cmd_ticks; // ticks spent in the command phase
	always_ff @(posedge sys_clk) begin
		if (!rst_n || state != S_CMD) cmd_ticks <= 8'h00;
		else if (cmd_ticks != 8'hFF) cmd_ticks <= cmd_ticks + 8'h01;
	end
	property p_len;
		@(posedge sys_clk) disable iff (!rst_n)
		(state == S_CMD && next_state != S_CMD) |-> cmd_ticks >= 8'(2 * ctrl[MCW_LSB +: MCW_W] + 1);
	endproperty
	a_len: assert property (p_len) else $error("cycle ended before programmed length"); // R01
	property p_delay;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(state == S_CMD) |-> (strobe_on == !ctrl[RW_DELAY_BIT]) ##1 strobe_on;
	endproperty
	a_delay: assert property (p_delay) else $error("strobe leading edge wrong"); // R02
	property p_wait;
		@(posedge sys_clk) disable iff (!rst_n)
		(sample_pt && ctrl[READY_EN_BIT] && !ready_active && waits != 8'hFF)
		|=> state == S_CMD && waits == $past(waits) + 8'h01 ##1 sample_pt;
	endproperty
	a_wait: assert property (p_wait) else $error("ready wait not inserted"); // R03
	property p_end;
		@(posedge sys_clk) disable iff (!rst_n)
		(sample_pt && ready_active) |=> rd_strobe_n && wr_strobe_n && state != S_CMD;
	endproperty
	a_end: assert property (p_end) else $error("active ready did not end cycle"); // R04
	property p_sync;
		@(posedge sys_clk) disable iff (!rst_n)
		(!ctrl[READY_ASYNC_BIT] && $stable(ctrl)) |-> ready_level == $past(ready_pin, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("aligned ready path delay wrong"); // R06
	property p_async;
		@(posedge sys_clk) disable iff (!rst_n)
		(ctrl[READY_ASYNC_BIT] && $stable(ctrl)) |-> ready_level == $past(ready_pin, 3);
	endproperty
	a_async: assert property (p_async) else $error("unaligned ready not synchronised"); // R07
	property p_mux;
		@(posedge sys_clk) disable iff (!rst_n)
		(sample_pt && ready_active && ctrl[MUX_BIT]) |=> state == S_MUX [*2] ##1 state != S_MUX;
	endproperty
	a_mux: assert property (p_mux) else $error("mux wait missing"); // R09
	property p_tri;
		@(posedge sys_clk) disable iff (!rst_n)
		(sample_pt && ready_active && !ctrl[MUX_BIT] && ctrl[TURNAROUND_BIT]) |=> state == S_TRI [*2];
	endproperty
	a_tri: assert property (p_tri) else $error("turnaround wait missing"); // R10
	property p_gap;
		@(posedge sys_clk) disable iff (!rst_n)
		(sample_pt && ready_active && ctrl[MUX_BIT] && ctrl[TURNAROUND_BIT] && $stable(ctrl))
		|=> bus_busy [*4] ##1 !bus_busy;
	endproperty
	a_gap: assert property (p_gap) else $error("post-cycle gap not two bus cycles"); // R11
	property p_start;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(state == S_ADDR) |-> $past(state) == S_IDLE;
	endproperty
	a_start: assert property (p_start) else $error("cycle started during waits"); // R12
	c_ready_wait: cover property (@(posedge sys_clk) disable iff (!rst_n) sample_pt && !ready_active ##2 sample_pt);
	c_mux_tri: cover property (@(posedge sys_clk) disable iff (!rst_n) state == S_MUX ##2 state == S_TRI);
	c_back: cover property (@(posedge sys_clk) disable iff (!rst_n) state == S_CMD ##1 state == S_IDLE ##1 state == S_ADDR);
endmodule // ext_bus_ready_wait_control
`default_nettype wire

// *** src/ready_sync.sv ***
// two- and three-stage synchroniser for the ready pin
`default_nettype none
module ready_sync (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ready_pin,
	output logic ready_sync2,
	output logic ready_sync3
);
	// ----------------------------------------------------------------------
	// chain: stage one is read only by stage two
	// ----------------------------------------------------------------------
	logic meta; // metastable capture stage
	logic next_meta;
	logic next_sync2;
	logic next_sync3;
	always_comb begin
		next_meta = ready_pin;
		next_sync2 = meta;
		next_sync3 = ready_sync2; // extra stage for unaligned ready
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			meta <= 1'b1;
			ready_sync2 <= 1'b1;
			ready_sync3 <= 1'b1;
		end else begin
			meta <= next_meta;
			ready_sync2 <= next_sync2;
			ready_sync3 <= next_sync3;
		end
	end
endmodule // ready_sync
`default_nettype wire

// *** src/ready_wait_pkg.sv ***
// constants, register map and state type of the external bus wait-state controller
`default_nettype none
package ready_wait_pkg;
	// ----------------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------------
	localparam int SYS_PERIOD_NS = 4; // sys_clk period at 250 MHz
	localparam int HALF_CPU_CLOCK_PERIOD_NS = SYS_PERIOD_NS; // one sys_clk per bus clock half
	localparam int ASYNC_READY_MIN_NS = 2 * HALF_CPU_CLOCK_PERIOD_NS + 7; // least async ready active time
	localparam int ASYNC_READY_MIN_CYC = (ASYNC_READY_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	// ----------------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------------
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] CMD_OFFSET = 4'h4;
	localparam logic [3:0] STATUS_OFFSET = 4'h8;
	// ----------------------------------------------------------------------
	// control field positions and reset
	// ----------------------------------------------------------------------
	localparam int MCW_LSB = 0; // memory_cycle_wait_count [3:0]
	localparam int MCW_W = 4;
	localparam int RW_DELAY_BIT = 4;
	localparam int TURNAROUND_BIT = 5; // bus_turnaround_wait_enable
	localparam int MUX_BIT = 6;
	localparam int READY_EN_BIT = 7;
	localparam int READY_HIGH_BIT = 8; // 1: ready active high, 0: active low
	localparam int READY_ASYNC_BIT = 9;
	localparam int CTRL_W = 10;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
	// ----------------------------------------------------------------------
	// command and status fields
	// ----------------------------------------------------------------------
	localparam int CMD_WRITE_BIT = 0;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_PENDING_BIT = 1;
	localparam int ST_SHORT_BIT = 2; // write 1 to clear
	localparam int ST_WAITS_LSB = 8;
	localparam int ST_COUNT_LSB = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------------------------------------
	// cycle states
	// ----------------------------------------------------------------------
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_CMD, S_MUX, S_TRI} bus_state_e;
endpackage
`default_nettype wire
